/* verilog/gw_wake_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - inputs 9 to 12 may wake the device from hibernate
// - all hibernate wake fields for inputs 9 to 12 reset to zero
// - detect flags at bits 15:12, write one clears, bits 11:0 read zero
// - enable bits at 15:12, one enables startup, bits 7:0 read zero
// - edge bits at 11:8, one selects falling edge, zero rising
// - hold type latches the cause until software clears it
// - through type follows the input, nothing latched
// - hold select bit at one makes that input hold type
// - trigger type zero means level, which can wake from suspend
// - edge inputs are not accepted in suspend and cannot wake it
// - carrier-detect change from serial unit wakes from suspend
// - long-period real-time-clock interrupt wakes from suspend
module gw_wake_top (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// register bus
	input  wire logic [31:0]                  avs_address_i,
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [31:0]                  avs_writedata_i,
	input  wire logic [3:0]                   avs_byteenable_i,
	output logic      [31:0]                  avs_readdata_o,
	output logic                              avs_waitrequest_o,
	// pins and events
	input  wire logic [gw_pkg::GPIO_COUNT-1:0] gpio_i,
	input  wire logic                         serial_unit_dcd_change_i,
	input  wire logic                         long_period_rtc_interrupt_i,
	// power sequencer
	input  wire logic                         hibernate_i,
	input  wire logic                         suspend_i,
	input  wire logic                         wake_ack_i,
	output logic                              wake_request_o,
	output logic                              gpio_irq_o
);
	import gw_pkg::*;

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
		logic [31:0] byte_addr;
		byte_addr = {idx[29:0], 2'b00};
		hit = (addr == byte_addr);
	endfunction

	function automatic logic [15:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	logic [15:0]           wake_cause_q;
	logic [15:0]           wake_ctrl_q;
	logic [GPIO_COUNT-1:0] trig_type_q;
	logic [GPIO_COUNT-1:0] hold_sel_q;
	logic [2:0]            sus_cause_q;
	logic [WAKE_COUNT-1:0] wake_prev_q;
	logic                  ack_q;
	logic [31:0]           rdata_q;
	gw_phase_t             phase_q;
	gw_phase_t             phase_d;

	gw_cap_if cap_bus ();

	gw_capture u_capture (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cap   (cap_bus)
	);

	// ************************************************************
	// address decode, shared by the read and write paths
	// ************************************************************
	logic sel_stat_lo;
	logic sel_stat_hi;
	logic sel_type_lo;
	logic sel_type_hi;
	logic sel_hold_lo;
	logic sel_hold_hi;
	logic sel_cause;
	logic sel_ctrl;
	logic sel_sus;

	assign sel_stat_lo = hit(avs_address_i, GPIO_IRQ_STATUS_LOW_IDX);
	assign sel_stat_hi = hit(avs_address_i, GPIO_IRQ_STATUS_HIGH_IDX);
	assign sel_type_lo = hit(avs_address_i, GPIO_IRQ_TRIGGER_TYPE_LOW_IDX);
	assign sel_type_hi = hit(avs_address_i, GPIO_IRQ_TRIGGER_TYPE_HIGH_IDX);
	assign sel_hold_lo = hit(avs_address_i, GPIO_IRQ_HOLD_SELECT_LOW_IDX);
	assign sel_hold_hi = hit(avs_address_i, GPIO_IRQ_HOLD_SELECT_HIGH_IDX);
	assign sel_cause   = hit(avs_address_i, WAKEUP_CAUSE_STATUS_2_IDX);
	assign sel_ctrl    = hit(avs_address_i, WAKEUP_ENABLE_EDGE_2_IDX);
	assign sel_sus     = hit(avs_address_i, SUSPEND_WAKE_CAUSE_IDX);

	// ************************************************************
	// bus slave
	// ************************************************************
	logic        req;
	logic        wr_fire;
	logic [15:0] wmask;
	logic [15:0] wdata;
	logic [15:0] w1c;

	assign req     = avs_read_i | avs_write_i;
	// one wait state: data is looked up in the first cycle, handed over in the second
	assign avs_waitrequest_o = req & ~ack_q;
	assign wr_fire = avs_write_i & ack_q;
	assign wmask   = lane_mask(avs_byteenable_i);
	assign wdata   = avs_writedata_i[15:0];
	assign w1c     = wdata & wmask;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (avs_read_i & ~ack_q) begin
			rdata_q <= '0;
			if (sel_stat_lo) begin
				rdata_q[15:0] <= cap_bus.status[15:0];
			end else if (sel_stat_hi) begin
				rdata_q[15:0] <= cap_bus.status[31:16];
			end else if (sel_type_lo) begin
				rdata_q[15:0] <= trig_type_q[15:0];
			end else if (sel_type_hi) begin
				rdata_q[15:0] <= trig_type_q[31:16];
			end else if (sel_hold_lo) begin
				rdata_q[15:0] <= hold_sel_q[15:0];
			end else if (sel_hold_hi) begin
				rdata_q[15:0] <= hold_sel_q[31:16];
			end else if (sel_cause) begin
				rdata_q[15:0] <= wake_cause_q & DETECT_MASK;
			end else if (sel_ctrl) begin
				rdata_q[15:0] <= wake_ctrl_q & ENABLE_EDGE_MASK;
			end else if (sel_sus) begin
				rdata_q[15:0] <= {13'h0000, sus_cause_q};
			end
		end
	end

	assign avs_readdata_o = rdata_q;

	// ************************************************************
	// trigger type and hold select
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_type_q <= TRIG_TYPE_RESET;
		end else if (wr_fire) begin
			if (sel_type_lo) begin
				trig_type_q[15:0] <= (trig_type_q[15:0] & ~wmask) | (wdata & wmask);
			end else if (sel_type_hi) begin
				trig_type_q[31:16] <= (trig_type_q[31:16] & ~wmask) | (wdata & wmask);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_sel_q <= HOLD_SEL_RESET;
		end else if (wr_fire) begin
			if (sel_hold_lo) begin
				hold_sel_q[15:0] <= (hold_sel_q[15:0] & ~wmask) | (wdata & wmask);
			end else if (sel_hold_hi) begin
				hold_sel_q[31:16] <= (hold_sel_q[31:16] & ~wmask) | (wdata & wmask);
			end
		end
	end

	// ************************************************************
	// connection to the capture cells
	// ************************************************************
	logic [GPIO_COUNT-1:0] irq_clear;

	always_comb begin
		irq_clear = '0;
		if (wr_fire && sel_stat_lo) begin
			irq_clear[15:0] = w1c;
		end
		if (wr_fire && sel_stat_hi) begin
			irq_clear[31:16] = w1c;
		end
	end

	assign cap_bus.pins      = gpio_i;
	assign cap_bus.trig_type = trig_type_q;
	assign cap_bus.hold_sel  = hold_sel_q;
	assign cap_bus.clear     = irq_clear;
	assign cap_bus.suspend   = (phase_q == ST_SUSPEND);

	// registered so a through-type glitch on a pin reaches the line only if it is high at a clock edge
	logic irq_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |cap_bus.status;
		end
	end

	assign gpio_irq_o = irq_q;

	// ************************************************************
	// hibernate wake control and cause
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_ctrl_q <= WAKE_CTRL_RESET;
		end else if (wr_fire && sel_ctrl) begin
			// only enable and edge fields exist; the low byte stays zero
			wake_ctrl_q <= ((wake_ctrl_q & ~wmask) | (wdata & wmask)) & ENABLE_EDGE_MASK;
		end
	end

	logic [WAKE_COUNT-1:0] wake_pins;
	logic [WAKE_COUNT-1:0] wake_enable;
	logic [WAKE_COUNT-1:0] wake_falling;
	logic [WAKE_COUNT-1:0] wake_edge_seen;
	logic [WAKE_COUNT-1:0] wake_hit;
	logic                  in_hibernate;

	assign wake_pins    = gpio_i[WAKE_GPIO_LO +: WAKE_COUNT];
	assign wake_enable  = wake_ctrl_q[ENABLE_LSB +: WAKE_COUNT];
	assign wake_falling = wake_ctrl_q[EDGE_LSB +: WAKE_COUNT];
	assign in_hibernate = (phase_q == ST_HIBERNATE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_prev_q <= '0;
		end else begin
			wake_prev_q <= wake_pins;
		end
	end

	genvar w;
	generate
		for (w = 0; w < WAKE_COUNT; w++) begin : g_wake
			assign wake_edge_seen[w] = wake_falling[w] ? (wake_prev_q[w] & ~wake_pins[w])
			                                           : (~wake_prev_q[w] & wake_pins[w]);
			assign wake_hit[w] = in_hibernate & wake_enable[w] & wake_edge_seen[w];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_cause_q <= WAKE_CAUSE_RESET;
		end else begin
			for (int i = 0; i < WAKE_COUNT; i++) begin
				if (wake_hit[i]) begin
					wake_cause_q[DETECT_LSB + i] <= 1'b1;
				end else if (wr_fire && sel_cause
				             && w1c[DETECT_LSB + i]) begin
					wake_cause_q[DETECT_LSB + i] <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// suspend wake causes
	// ************************************************************
	logic [2:0] sus_hit;
	logic       in_suspend;

	assign in_suspend = (phase_q == ST_SUSPEND);
	// edge-type inputs are already kept out of level_active
	assign sus_hit[SUS_LEVEL_BIT] = in_suspend & (|cap_bus.level_active);
	assign sus_hit[SUS_DCD_BIT]   = in_suspend & serial_unit_dcd_change_i;
	assign sus_hit[SUS_RTC_BIT]   = in_suspend & long_period_rtc_interrupt_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sus_cause_q <= SUS_CAUSE_RESET;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (sus_hit[i]) begin
					sus_cause_q[i] <= 1'b1;
				end else if (wr_fire && sel_sus && w1c[i]) begin
					sus_cause_q[i] <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// power phase tracking and wake request
	// ************************************************************
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			ST_RUN: begin
				if (hibernate_i) begin
					phase_d = ST_HIBERNATE;
				end else if (suspend_i) begin
					phase_d = ST_SUSPEND;
				end
			end
			ST_HIBERNATE: begin
				if (|wake_hit) begin
					phase_d = ST_WAKE;
				end else if (!hibernate_i) begin
					phase_d = ST_RUN;
				end
			end
			ST_SUSPEND: begin
				// the serial clock mask is software's duty before this point
				if (|sus_hit) begin
					phase_d = ST_WAKE;
				end else if (!suspend_i) begin
					phase_d = ST_RUN;
				end
			end
			ST_WAKE: begin
				if (wake_ack_i) begin
					phase_d = ST_RUN;
				end
			end
			default: phase_d = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= ST_RUN;
		end else begin
			phase_q <= phase_d;
		end
	end

	// request stands until the sequencer acknowledges
	assign wake_request_o = (phase_q == ST_WAKE);

endmodule

/* verilog/gw_pkg.sv */
package gw_pkg;

	// ************************************************************
	// register map: printed offsets are register indices
	// ************************************************************
	localparam logic [31:0] GPIO_IRQ_STATUS_LOW_IDX       = 32'h00b00108;
	localparam logic [31:0] GPIO_IRQ_STATUS_HIGH_IDX      = 32'h0b00010a;
	localparam logic [31:0] GPIO_IRQ_TRIGGER_TYPE_LOW_IDX  = 32'h0b000110;
	localparam logic [31:0] GPIO_IRQ_TRIGGER_TYPE_HIGH_IDX = 32'h0b000112;
	localparam logic [31:0] GPIO_IRQ_HOLD_SELECT_LOW_IDX   = 32'h0b000118;
	localparam logic [31:0] GPIO_IRQ_HOLD_SELECT_HIGH_IDX  = 32'h0b00011a;
	localparam logic [31:0] WAKEUP_CAUSE_STATUS_2_IDX      = 32'h0b0000a4;
	localparam logic [31:0] WAKEUP_ENABLE_EDGE_2_IDX       = 32'h0b0000a6;
	localparam logic [31:0] SUSPEND_WAKE_CAUSE_IDX         = 32'h0b0000a8;

	// ************************************************************
	// field layout
	// ************************************************************
	localparam int unsigned GPIO_COUNT      = 32;
	localparam int unsigned REG_WIDTH       = 16;
	localparam int unsigned WAKE_GPIO_LO    = 9;
	localparam int unsigned WAKE_COUNT      = 4;
	localparam int unsigned DETECT_LSB      = 12;
	localparam int unsigned ENABLE_LSB      = 12;
	localparam int unsigned EDGE_LSB        = 8;
	localparam int unsigned SUS_LEVEL_BIT   = 0;
	localparam int unsigned SUS_DCD_BIT     = 1;
	localparam int unsigned SUS_RTC_BIT     = 2;
	localparam logic [15:0] DETECT_MASK     = 16'hf000;
	localparam logic [15:0] ENABLE_EDGE_MASK = 16'hff00;
	localparam logic [15:0] SUS_CAUSE_MASK  = 16'h0007;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] WAKE_CAUSE_RESET  = 16'h0000;
	localparam logic [15:0] WAKE_CTRL_RESET   = 16'h0000;
	localparam logic [31:0] TRIG_TYPE_RESET   = 32'h00000000;
	localparam logic [31:0] HOLD_SEL_RESET    = 32'h00000000;
	localparam logic [2:0]  SUS_CAUSE_RESET   = 3'h0;

	// ************************************************************
	// power phase states
	// ************************************************************
	typedef enum logic [3:0] {
		ST_RUN       = 4'b0001,
		ST_HIBERNATE = 4'b0010,
		ST_SUSPEND   = 4'b0100,
		ST_WAKE      = 4'b1000
	} gw_phase_t;

endpackage

/* verilog/gw_cap_if.sv */
`timescale 1ns/1ps
interface gw_cap_if;
	import gw_pkg::*;
	logic [GPIO_COUNT-1:0] pins;
	logic [GPIO_COUNT-1:0] trig_type;
	logic [GPIO_COUNT-1:0] hold_sel;
	logic [GPIO_COUNT-1:0] clear;
	logic                  suspend;
	logic [GPIO_COUNT-1:0] status;
	logic [GPIO_COUNT-1:0] level_active;

	modport cap (
		input  pins, trig_type, hold_sel, clear, suspend,
		output status, level_active
	);
	modport ctl (
		output pins, trig_type, hold_sel, clear, suspend,
		input  status, level_active
	);
endinterface

/* verilog/gw_capture.sv */
`timescale 1ns/1ps
module gw_capture (
	input  wire logic clk_i,
	input  wire logic rst_i,
	gw_cap_if.cap     cap
);
	import gw_pkg::*;

	logic [GPIO_COUNT-1:0] pin_prev_q;
	logic [GPIO_COUNT-1:0] held_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= cap.pins;
		end
	end

	genvar g;
	generate
		for (g = 0; g < GPIO_COUNT; g++) begin : g_bit
			logic edge_evt;
			logic level_evt;
			logic evt;
			// edge inputs are sampled on a clock that is stopped in suspend
			assign edge_evt  = cap.pins[g] & ~pin_prev_q[g] & ~cap.suspend;
			assign level_evt = cap.pins[g];
			assign evt       = cap.trig_type[g] ? edge_evt : level_evt;

			// hold type: sticky until write-one-clear; a new event beats the clear
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					held_q[g] <= 1'b0;
				end else if (evt) begin
					held_q[g] <= 1'b1;
				end else if (cap.clear[g]) begin
					held_q[g] <= 1'b0;
				end
			end

			// through type follows the input and keeps nothing
			assign cap.status[g] = cap.hold_sel[g] ? held_q[g] : evt;
			assign cap.level_active[g] = ~cap.trig_type[g] & cap.status[g];
		end
	endgenerate

endmodule

/* bench/gw_wake_properties.sv */
`timescale 1ns/1ps
module gw_wake_properties (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_readdata_o,
	input  wire logic        avs_waitrequest_o,
	input  wire logic        serial_unit_dcd_change_i,
	input  wire logic        long_period_rtc_interrupt_i,
	input  wire logic        hibernate_i,
	input  wire logic        suspend_i,
	input  wire logic        wake_ack_i,
	input  wire logic        wake_request_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ************************************************************
	// sequences
	// ************************************************************
	sequence s_req_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	// settled in suspend: entered a cycle ago, no hibernate, no pending ack
	sequence s_suspended;
		suspend_i && $past(suspend_i) && !hibernate_i && !$past(hibernate_i) && !wake_ack_i;
	endsequence

	// ************************************************************
	// assertions
	// ************************************************************
	AST_WAIT_FIRST: assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i)
		|-> avs_waitrequest_o) else $error("no wait state on first request cycle");
	AST_WAIT_ONE: assert property (s_req_wait ##1 (avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("more than one wait state");
	AST_READ_UPPER_ZERO: assert property (avs_read_i && !avs_waitrequest_o
		|-> avs_readdata_o[31:16] == 16'h0000) else $error("upper read data not zero");
	AST_RESET_IDLE: assert property ($fell(rst_i) |-> !wake_request_o)
		else $error("wake request after reset");
	AST_WAKE_STAYS: assert property (wake_request_o && !wake_ack_i |=> wake_request_o)
		else $error("wake request dropped without ack");
	AST_WAKE_ENDS: assert property (wake_request_o && wake_ack_i |=> !wake_request_o)
		else $error("wake request held after ack");
	AST_WAKE_CAUSE: assert property ($rose(wake_request_o)
		|-> $past(hibernate_i) || $past(suspend_i))
		else $error("wake request outside low power mode");
	AST_DCD_WAKE: assert property (s_suspended ##0 serial_unit_dcd_change_i
		|-> ##[1:5] wake_request_o) else $error("carrier change did not wake");
	AST_RTC_WAKE: assert property (s_suspended ##0 long_period_rtc_interrupt_i
		|-> ##[1:5] wake_request_o) else $error("rtc long did not wake");
endmodule

bind gw_wake_top gw_wake_properties gw_wake_properties_i (
	.clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.serial_unit_dcd_change_i(serial_unit_dcd_change_i),
	.long_period_rtc_interrupt_i(long_period_rtc_interrupt_i), .hibernate_i(hibernate_i),
	.suspend_i(suspend_i), .wake_ack_i(wake_ack_i), .wake_request_o(wake_request_o)
);

/* bench/gw_seq_model.sv */
`timescale 1ns/1ps
module gw_seq_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic go_hib_i,
	input  wire logic go_sus_i,
	input  wire logic slow_i,
	input  wire logic wake_request_i,
	output logic      hibernate_o,
	output logic      suspend_o,
	output logic      wake_ack_o
);
	logic [2:0] wait_q;
	// a slow sequencer lets the request stand several cycles before ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hibernate_o <= 1'b0;
			suspend_o   <= 1'b0;
			wake_ack_o  <= 1'b0;
			wait_q      <= 3'h0;
		end else if (wake_ack_o) begin
			wake_ack_o <= 1'b0;
		end else if (wake_request_i) begin
			wait_q <= wait_q + 3'h1;
			if (!slow_i || wait_q == 3'h5) begin
				wake_ack_o  <= 1'b1;
				hibernate_o <= 1'b0;
				suspend_o   <= 1'b0;
				wait_q      <= 3'h0;
			end
		end else begin
			if (go_hib_i) hibernate_o <= 1'b1;
			// serial clock gating before suspend is left to software
			if (go_sus_i) suspend_o <= 1'b1;
		end
	end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %0t %s", $time, m); end end
module tb_top;
	import gw_pkg::*;
	logic        clk, rst, rd_en, wr_en, waitreq, dcd, rtc, hib, sus, ack, wreq, irq;
	logic        go_hib, go_sus, slow, e;
	logic [31:0] addr, wdata, rdata, r, gpio;
	int          num_errors = 0, compares = 0, cycles = 0, seed, rv, k, b;
	logic [31:0] regs [9] = '{WAKEUP_CAUSE_STATUS_2_IDX, WAKEUP_ENABLE_EDGE_2_IDX,
		GPIO_IRQ_TRIGGER_TYPE_LOW_IDX, GPIO_IRQ_TRIGGER_TYPE_HIGH_IDX, GPIO_IRQ_HOLD_SELECT_LOW_IDX,
		GPIO_IRQ_HOLD_SELECT_HIGH_IDX, GPIO_IRQ_STATUS_LOW_IDX, GPIO_IRQ_STATUS_HIGH_IDX,
		SUSPEND_WAKE_CAUSE_IDX};
	int          cbit [3] = '{SUS_DCD_BIT, SUS_LEVEL_BIT, SUS_RTC_BIT};

	gw_wake_top gw_wake_top_i (.clk_i(clk), .rst_i(rst), .avs_address_i(addr),
		.avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'h3), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.gpio_i(gpio), .serial_unit_dcd_change_i(dcd), .long_period_rtc_interrupt_i(rtc),
		.hibernate_i(hib), .suspend_i(sus), .wake_ack_i(ack), .wake_request_o(wreq),
		.gpio_irq_o(irq));
	gw_seq_model gw_seq_model_i (.clk_i(clk), .rst_i(rst), .go_hib_i(go_hib), .go_sus_i(go_sus),
		.slow_i(slow), .wake_request_i(wreq), .hibernate_o(hib), .suspend_o(sus),
		.wake_ack_o(ack));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// whole run needs a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("MISMATCH %0t timeout", $time);
			finish_test();
		end
	end

	task finish_test;
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one avalon access, held until waitrequest is seen low
	task acc(input logic w, input logic [31:0] idx, input logic [15:0] d);
		@(posedge clk);
		addr  <= idx << 2;
		rd_en <= !w;
		wr_en <= w;
		wdata <= {16'h0000, d};
		do @(posedge clk); while (waitreq !== 1'b0);
		r = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	task rdc(input logic [31:0] idx, input logic [15:0] x, input string m);
		acc(1'b0, idx, 16'h0000);
		`CHK(r, {16'h0000, x}, m)
	endtask
	// look for a wake request within n cycles, then let the ack finish
	task wake(input int n, input logic x, input string m);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk);
			if (wreq === 1'b1) seen = 1'b1;
		end
		`CHK(seen, x, m)
		while (wreq !== 1'b0) @(posedge clk);
	endtask

	initial begin
		seed = 54348;
		{rst, rd_en, wr_en, dcd, rtc, go_hib, go_sus, slow} = 8'h80;
		addr = 32'h0;
		wdata = 32'h0;
		gpio = 32'h0;
		tick(12);
		rst <= 1'b0;
		foreach (regs[i]) rdc(regs[i], 16'h0000, "reset value");
		acc(1'b1, WAKEUP_ENABLE_EDGE_2_IDX, 16'hffff);
		rdc(WAKEUP_ENABLE_EDGE_2_IDX, 16'hff00, "control reserved bits");
		acc(1'b1, WAKEUP_CAUSE_STATUS_2_IDX, 16'hffff);
		rdc(WAKEUP_CAUSE_STATUS_2_IDX, 16'h0000, "cause reads zero");
		acc(1'b1, 32'h0b0000fe, 16'hffff);
		rdc(32'h0b0000fe, 16'h0000, "unmapped");
		for (k = 0; k < 4; k++) begin
			rv = $random(seed);
			e = rv[0];
			slow <= rv[1];
			gpio[9+k] <= !e;
			acc(1'b1, WAKEUP_ENABLE_EDGE_2_IDX, (16'h1000 << k) | ({15'h0, e} << (8 + k)));
			go_hib <= 1'b1;
			tick(1);
			go_hib <= 1'b0;
			tick(2);
			gpio[9+(k+1)%4] <= 1'b1;
			tick(2);
			gpio[9+(k+1)%4] <= 1'b0;
			tick(2);
			gpio[9+k] <= e;
			wake(6, 1'b0, "wrong or disabled edge woke");
			gpio[9+k] <= !e;
			wake(8, 1'b1, "hibernate wake");
			rdc(WAKEUP_CAUSE_STATUS_2_IDX, 16'h1000 << k, "detect flag");
			acc(1'b1, WAKEUP_CAUSE_STATUS_2_IDX, 16'h1000 << k);
			rdc(WAKEUP_CAUSE_STATUS_2_IDX, 16'h0000, "flag clear");
			gpio[9+k] <= 1'b0;
		end
		for (k = 0; k < 2; k++) begin
			rv = $random(seed);
			b = rv & 7;
			acc(1'b1, GPIO_IRQ_HOLD_SELECT_LOW_IDX, 16'(k) << b);
			gpio[b] <= 1'b1;
			tick(3);
			rdc(GPIO_IRQ_STATUS_LOW_IDX, 16'h1 << b, "level status");
			`CHK(irq, 1'b1, "irq raised")
			gpio[b] <= 1'b0;
			tick(3);
			rdc(GPIO_IRQ_STATUS_LOW_IDX, 16'(k) << b, "held or followed");
			`CHK(irq, k[0], "irq after release")
			acc(1'b1, GPIO_IRQ_STATUS_LOW_IDX, 16'h1 << b);
			rdc(GPIO_IRQ_STATUS_LOW_IDX, 16'h0000, "status clear");
		end
		gpio[16+b] <= 1'b1;
		tick(2);
		rdc(GPIO_IRQ_STATUS_HIGH_IDX, 16'h1 << b, "upper status follows");
		gpio[16+b] <= 1'b0;
		rv = $random(seed);
		b = rv & 7;
		acc(1'b1, GPIO_IRQ_TRIGGER_TYPE_LOW_IDX, 16'h1 << b);
		for (k = 0; k < 3; k++) begin
			go_sus <= 1'b1;
			tick(1);
			go_sus <= 1'b0;
			tick(2);
			if (k == 0) begin
				gpio[b] <= 1'b1;
				wake(6, 1'b0, "edge gpio woke suspend");
				gpio[b] <= 1'b0;
				tick(1);
			end
			dcd <= (k == 0);
			gpio[b^1] <= (k == 1);
			rtc <= (k == 2);
			tick(1);
			dcd <= 1'b0;
			rtc <= 1'b0;
			wake(8, 1'b1, "suspend wake");
			gpio[b^1] <= 1'b0;
			// a hold-type pin would keep the level cause alive into the next suspend
			acc(1'b1, GPIO_IRQ_STATUS_LOW_IDX, 16'h00ff);
			rdc(SUSPEND_WAKE_CAUSE_IDX, 16'h1 << cbit[k], "suspend cause");
			acc(1'b1, SUSPEND_WAKE_CAUSE_IDX, 16'h0007);
			rdc(SUSPEND_WAKE_CAUSE_IDX, 16'h0000, "suspend cause clear");
		end
		rtc <= 1'b1;
		tick(1);
		rtc <= 1'b0;
		wake(6, 1'b0, "event outside mode woke");
		finish_test();
	end
endmodule
